// >>> rtl/mbx_engine_end.sv
// mbx_engine_end.sv: modem engine command decoder behind the three-byte mailbox
// assumes: host writes one command per exchange; memory and front end are outside
// Behaviour
// - parameter commands: byte0 opcode, bytes1-2 data
// - plain commands match all 24 bits
// - host sends idle command when nothing needed
// - idle leaves state, training continues
// - one answer-expecting command outstanding at once
// - begin training; status shows progress, outcome
// - init restores defaults, then awaits commands
// - retrain command starts retrain sequence
// - four opcodes freeze/unfreeze canceller, equalizer
// - training end enables scramblers; command sets transmit on or off from byte 1
// - gain from bytes1-2 scales every transmit sample
// - separate opcodes stop fax transmit, sync receive
// - serial mode routes data; host avoids send_data
// - serial mode interrupt period up to limit; SERIAL_PERIOD_CYC is defined but no logic here times the period
// - store word at address; variant increments address
// - load address low-first, return addressed word
// - pair read: high bytes of two words
// - configuration opcodes select modem family
// - front end setup, two reads, two writes
// - tone select programs, does not enable
// - tone define loads phase step, no enable
// - tone enable per generator; tone b louder
// - host writes three bytes, reads three
`timescale 1ns/1ps
`include "mbx_cmd_defs.svh"
module mbx_engine_end (
	// clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       nrst_i,
	// mailbox
	mbx_link_if.engine                      link,
	// memory access port (engine memories, read without stopping processors)
	output logic [15:0]                     mem_addr_o,
	output logic [15:0]                     mem_wdata_o,
	output logic                            mem_we_o,
	input  wire logic [15:0]                mem_rdata_i,
	input  wire logic [15:0]                mem_rdata_next_i,
	// front end
	output logic [15:0]                     fe_data_o,
	output logic                            fe_setup_o,
	output logic                            fe_write_a_o,
	output logic                            fe_write_b_o,
	input  wire logic [11:0]                fe_status_a_i,
	input  wire logic [11:0]                fe_status_b_i,
	// transmit path
	input  wire logic [15:0]                tx_sample_i,
	output logic [15:0]                     tx_sample_o,
	// modem control
	output mbx_cmd_pkg::call_phase_e        phase_o,
	output mbx_cmd_pkg::modem_family_e      family_o,
	output logic [7:0]                      family_opts_o,
	output logic                            retrain_o,
	output logic                            ec_frozen_o,
	output logic                            eq_frozen_o,
	output logic                            tx_scrambler_on_o,
	output logic                            rx_scrambler_on_o,
	output logic                            fax_tx_stop_o,
	output logic                            fax_rx_sync_o,
	output logic                            serial_mode_o,
	output logic [15:0]                     serial_cfg_o,
	output logic                            send_data_o,
	output logic [7:0]                      send_byte_o,
	// tone generators
	output logic [15:0]                     tone_a_step_o,
	output logic [15:0]                     tone_b_step_o,
	output logic [15:0]                     tone_select_o,
	output logic                            tone_a_on_o,
	output logic                            tone_b_on_o,
	output logic [7:0]                      tone_b_boost_db_o
);
	typedef enum logic [1:0] { st_idle, st_answer } eng_state_e;
	eng_state_e                  state_reg, state_next;
	mbx_cmd_pkg::call_phase_e    phase_reg;
	mbx_cmd_pkg::modem_family_e  family_reg;
	logic [7:0]  family_opts_reg, train_cnt_reg;
	logic [15:0] gain_reg, addr_reg, mem_wdata_reg, fe_data_reg, serial_cfg_reg;
	logic [15:0] tone_a_reg, tone_b_reg, tone_sel_reg, tx_sample_reg;
	logic        mem_we_reg, fe_setup_reg, fe_wa_reg, fe_wb_reg, retrain_reg;
	logic        ec_frz_reg, eq_frz_reg, tx_scr_reg, rx_scr_reg, fax_stop_reg;
	logic        fax_sync_reg, serial_reg, send_reg, tone_a_on_reg, tone_b_on_reg;
	logic [7:0]  send_byte_reg;
	logic [23:0] resp_reg;
	logic        resp_valid_reg, ready_reg, inc_pend_reg;
	logic [1:0]  ans_kind_reg;
	function automatic logic [15:0] pair16(input logic [23:0] w);
		pair16 = {w[`CMD_B2_MSB:`CMD_B2_LSB], w[`CMD_B1_MSB:`CMD_B1_LSB]};
	endfunction : pair16
	function automatic logic [15:0] scale(input logic [15:0] s, input logic [15:0] g);
		logic [31:0] p;
		p     = $signed(s) * $signed(g);
		scale = p[29:14];
	endfunction : scale
	wire [23:0] cw   = link.cmd_word;
	wire        cv   = link.cmd_valid;
	wire [7:0]  op   = cw[`CMD_B0_MSB:`CMD_B0_LSB];
	wire [7:0]  b1   = cw[`CMD_B1_MSB:`CMD_B1_LSB];
	wire [15:0] prm  = pair16(cw);
	// plain commands compare the full word; byte 0 alone never matches them
	wire is_idle     = cv && cw == `OPF_IDLE;
	wire is_train    = cv && cw == `OPF_BEGIN_TRAINING;
	wire is_retrain  = cv && cw == `OPF_RETRAIN;
	wire is_init     = cv && cw == `OPF_INIT;
	wire is_rd_a     = cv && cw == `OPF_FE_READ_A;
	wire is_rd_b     = cv && cw == `OPF_FE_READ_B;
	wire is_load_rd  = cv && op == `OPS_LOAD_ADDR_RD;
	wire is_load_pr  = cv && op == `OPS_LOAD_ADDR_PAIR;
	wire is_store    = cv && (op == `OPS_STORE_WORD || op == `OPS_STORE_INC);
	wire train_done  = phase_reg == mbx_cmd_pkg::ph_handshake && train_cnt_reg == `TRAIN_ONE;
	wire [1:0] ans_kind_next = {is_load_pr || is_rd_b, is_load_rd || is_rd_b};
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_idle:   state_next = (is_load_rd || is_load_pr || is_rd_a || is_rd_b)
				? st_answer : st_idle;
			st_answer: state_next = st_idle;
			default:   state_next = st_idle;
		endcase
	end
	// answer bytes: pending answer replaces status bytes for one exchange
	wire [15:0] ans_word = (ans_kind_reg == 2'd1) ? mem_rdata_i
		: (ans_kind_reg == 2'd2) ? {mem_rdata_i[15:8], mem_rdata_next_i[15:8]}
		: (ans_kind_reg == 2'd3) ? {4'h0, fe_status_b_i} : {4'h0, fe_status_a_i};
	// status byte 0: phase bits, training flag
	wire [7:0]  stat0    = {4'h0, 2'(phase_reg), phase_reg == mbx_cmd_pkg::ph_handshake,
		1'b0};
	wire [23:0] resp_next = (state_reg == st_answer) ? {stat0, ans_word[15:8], ans_word[7:0]}
		: {stat0, `ANS_NONE, `ANS_NONE};
	wire        resp_fire = state_reg == st_answer || (cv && state_next == st_idle);
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg      <= st_idle;
			ans_kind_reg   <= 2'd0;
			resp_reg       <= `OPF_IDLE;
			resp_valid_reg <= 1'b0;
			ready_reg      <= 1'b0;
		end else begin
			state_reg      <= state_next;
			ready_reg      <= !cv;
			resp_valid_reg <= resp_fire;
			if (resp_fire) resp_reg <= resp_next;
			ans_kind_reg   <= ans_kind_next;
		end
	end
	// one-cycle strobes, the data they carry (held between commands), and the scaled transmit sample
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{mem_we_reg, fe_setup_reg, fe_wa_reg, fe_wb_reg, retrain_reg} <= 5'h00;
			{fax_stop_reg, fax_sync_reg, send_reg, inc_pend_reg} <= 4'h0;
			mem_wdata_reg <= `ZERO16;
			fe_data_reg   <= `ZERO16;
			send_byte_reg <= `ANS_NONE;
			tx_sample_reg <= `ZERO16;
		end else begin
			mem_we_reg    <= is_store;
			inc_pend_reg  <= cv && op == `OPS_STORE_INC;
			mem_wdata_reg <= is_store ? prm : mem_wdata_reg;
			fe_setup_reg  <= cv && op == `OPS_FE_SETUP;
			fe_wa_reg     <= cv && op == `OPS_FE_WRITE_A;
			fe_wb_reg     <= cv && op == `OPS_FE_WRITE_B;
			fe_data_reg   <= (cv && (op == `OPS_FE_SETUP || op == `OPS_FE_WRITE_A
				|| op == `OPS_FE_WRITE_B)) ? prm : fe_data_reg;
			retrain_reg   <= is_retrain;
			fax_stop_reg  <= cv && op == `OPS_FAX_STOP;
			fax_sync_reg  <= cv && op == `OPS_FAX_SYNC;
			send_reg      <= cv && op == `OPS_SEND_DATA && !serial_reg;
			send_byte_reg <= (cv && op == `OPS_SEND_DATA) ? b1 : send_byte_reg;
			tx_sample_reg <= scale(tx_sample_i, gain_reg);
		end
	end
	// persistent modem state; idle touches only the training counter
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_reg       <= mbx_cmd_pkg::ph_call_setup;
			family_reg      <= mbx_cmd_pkg::fam_high_speed;
			family_opts_reg <= `ANS_NONE;
			train_cnt_reg   <= `TRAIN_ZERO;
			gain_reg        <= `GAIN_DEFAULT;
			addr_reg        <= `ADDR_DEFAULT;
			{ec_frz_reg, eq_frz_reg, tx_scr_reg, rx_scr_reg, serial_reg} <= 5'h00;
			serial_cfg_reg  <= `ZERO16;
			{tone_a_reg, tone_b_reg, tone_sel_reg} <= {3{`ZERO16}};
			{tone_a_on_reg, tone_b_on_reg} <= 2'b00;
		end else if (is_init) begin
			phase_reg       <= mbx_cmd_pkg::ph_call_setup;
			family_reg      <= mbx_cmd_pkg::fam_high_speed;
			family_opts_reg <= `ANS_NONE;
			train_cnt_reg   <= `TRAIN_ZERO;
			gain_reg        <= `GAIN_DEFAULT;
			addr_reg        <= `ADDR_DEFAULT;
			{ec_frz_reg, eq_frz_reg, tx_scr_reg, rx_scr_reg, serial_reg} <= 5'h00;
			serial_cfg_reg  <= `ZERO16;
			{tone_a_reg, tone_b_reg, tone_sel_reg} <= {3{`ZERO16}};
			{tone_a_on_reg, tone_b_on_reg} <= 2'b00;
		end else begin
			// training runs on through idle commands until its counter ends
			if (is_train || is_retrain) begin
				phase_reg     <= mbx_cmd_pkg::ph_handshake;
				train_cnt_reg <= `TRAIN_EXCHANGES;
			end else if (train_done) begin
				phase_reg     <= mbx_cmd_pkg::ph_data;
				train_cnt_reg <= `TRAIN_ZERO;
				tx_scr_reg    <= 1'b1;
				rx_scr_reg    <= 1'b1;
			end else if (phase_reg == mbx_cmd_pkg::ph_handshake && cv) begin
				train_cnt_reg <= train_cnt_reg - `TRAIN_ONE;
			end
			if (cv && op == `OPS_SCRAMBLER) tx_scr_reg <= b1 != `ANS_NONE;
			if (is_idle) serial_cfg_reg <= serial_cfg_reg;
			if (cw == `OPF_FREEZE_EC && cv) ec_frz_reg <= 1'b1;
			if (cw == `OPF_UNFREEZE_EC && cv) ec_frz_reg <= 1'b0;
			if (cw == `OPF_FREEZE_EQ && cv) eq_frz_reg <= 1'b1;
			if (cw == `OPF_UNFREEZE_EQ && cv) eq_frz_reg <= 1'b0;
			if (cv && op == `OPS_TX_GAIN) gain_reg <= prm;
			if (cv && op == `OPS_SERIAL_MODE) begin
				serial_reg     <= prm != `ZERO16;
				serial_cfg_reg <= prm;
			end
			if (is_load_rd || is_load_pr) addr_reg <= prm;
			else if (inc_pend_reg) addr_reg <= addr_reg + 16'h0001;
			if (cv && op == `OPS_CFG_HIGH) begin
				family_reg      <= mbx_cmd_pkg::fam_high_speed;
				family_opts_reg <= b1;
			end
			if (cv && op == `OPS_CFG_FSK) family_reg <= mbx_cmd_pkg::fam_fsk;
			if (cv && op == `OPS_CFG_FAX) family_reg <= mbx_cmd_pkg::fam_facsimile;
			if (cv && op == `OPS_CFG_MEDIUM) family_reg <= mbx_cmd_pkg::fam_medium_speed;
			if (cv && op == `OPS_TONE_SELECT) tone_sel_reg <= prm;
			if (cv && op == `OPS_TONE_A_DEF) tone_a_reg <= prm;
			if (cv && op == `OPS_TONE_B_DEF) tone_b_reg <= prm;
			if (cv && op == `OPS_TONE_ENABLE) begin
				tone_a_on_reg <= b1[`TONE_A_EN_BIT];
				tone_b_on_reg <= b1[`TONE_B_EN_BIT];
			end
		end
	end

	assign link.resp_word    = resp_reg;
	assign link.resp_valid   = resp_valid_reg;
	assign link.engine_ready = ready_reg;
	assign mem_addr_o        = addr_reg;
	assign mem_wdata_o       = mem_wdata_reg;
	assign mem_we_o          = mem_we_reg;
	assign fe_data_o         = fe_data_reg;
	assign fe_setup_o        = fe_setup_reg;
	assign fe_write_a_o      = fe_wa_reg;
	assign fe_write_b_o      = fe_wb_reg;
	assign tx_sample_o       = tx_sample_reg;
	assign phase_o           = phase_reg;
	assign family_o          = family_reg;
	assign family_opts_o     = family_opts_reg;
	assign retrain_o         = retrain_reg;
	assign ec_frozen_o       = ec_frz_reg;
	assign eq_frozen_o       = eq_frz_reg;
	assign tx_scrambler_on_o = tx_scr_reg;
	assign rx_scrambler_on_o = rx_scr_reg;
	assign fax_tx_stop_o     = fax_stop_reg;
	assign fax_rx_sync_o     = fax_sync_reg;
	assign serial_mode_o     = serial_reg;
	assign serial_cfg_o      = serial_cfg_reg;
	assign send_data_o       = send_reg;
	assign send_byte_o       = send_byte_reg;
	assign tone_a_step_o     = tone_a_reg;
	assign tone_b_step_o     = tone_b_reg;
	assign tone_select_o     = tone_sel_reg;
	assign tone_a_on_o       = tone_a_on_reg;
	assign tone_b_on_o       = tone_b_on_reg;
	// fixed relative boost; the tone synthesiser applies it when both run
	assign tone_b_boost_db_o = 8'(`TONE_B_GAIN_DB);
endmodule : mbx_engine_end

// >>> rtl/mbx_cmd_defs.svh
// mbx_cmd_defs.svh: opcodes, field positions, reset values and timing constants
// assumes: included by the engine, host and classify design files by bare name
`ifndef MBX_CMD_DEFS_SVH
`define MBX_CMD_DEFS_SVH

// full-width opcodes (no parameters)
`define OPF_IDLE           24'h000000
`define OPF_BEGIN_TRAINING 24'h040000
`define OPF_RETRAIN        24'h050000
`define OPF_INIT           24'h0600c0
`define OPF_FE_READ_A      24'h080000
`define OPF_FE_READ_B      24'h090000
`define OPF_FREEZE_EC      24'h160000
`define OPF_UNFREEZE_EC    24'h170000
`define OPF_FREEZE_EQ      24'h1b0000
`define OPF_UNFREEZE_EQ    24'h1c0000
// short opcodes (byte 0, parameters in bytes 1 and 2)
`define OPS_SEND_DATA      8'h01
`define OPS_TX_GAIN        8'h02
`define OPS_FE_SETUP       8'h07
`define OPS_FE_WRITE_A     8'h0a
`define OPS_FE_WRITE_B     8'h0b
`define OPS_TONE_SELECT    8'h0c
`define OPS_TONE_ENABLE    8'h0d
`define OPS_TONE_A_DEF     8'h0e
`define OPS_TONE_B_DEF     8'h0f
`define OPS_LOAD_ADDR_RD   8'h10
`define OPS_LOAD_ADDR_PAIR 8'h11
`define OPS_STORE_WORD     8'h12
`define OPS_STORE_INC      8'h13
`define OPS_SERIAL_MODE    8'h15
`define OPS_SCRAMBLER      8'h18
`define OPS_FAX_STOP       8'h19
`define OPS_FAX_SYNC       8'h1a
`define OPS_CFG_FSK        8'h1d
`define OPS_CFG_MEDIUM     8'h1e
`define OPS_CFG_FAX        8'h1f
`define OPS_CFG_HIGH       8'h20

// command word layout
`define CMD_B0_MSB 23
`define CMD_B0_LSB 16
`define CMD_B1_MSB 15
`define CMD_B1_LSB 8
`define CMD_B2_MSB 7
`define CMD_B2_LSB 0
// field bits inside byte 1 of the tone enable command
`define TONE_A_EN_BIT 0
`define TONE_B_EN_BIT 1

// reset / init values
`define GAIN_DEFAULT   16'h4000
`define ADDR_DEFAULT   16'h0000
`define ZERO16         16'h0000
`define ANSWER_TONE_PARAM 16'h0010
// tone b louder than tone a
`define TONE_B_GAIN_DB 2
// phase step for +180 degrees
`define PHASE_HALF_TURN 16'h7fff

// answer-byte layout: bytes 1 and 2 of the status word
`define ANS_NONE 8'h00

// training length in host exchanges (no algorithm here; a stand-in counter)
`define TRAIN_EXCHANGES 8'h20
`define TRAIN_ONE       8'h01
`define TRAIN_ZERO      8'h00

// serial-mode host interrupt period limit
`define SERIAL_PERIOD_MAX_MS 100
`define CLK_MHZ              50
`define SERIAL_PERIOD_CYC    (`SERIAL_PERIOD_MAX_MS * 1000 * `CLK_MHZ)

`endif

// >>> rtl/mbx_cmd_pkg.sv
// mbx_cmd_pkg.sv: types shared by both mailbox ends
// assumes: mbx_cmd_defs.svh is on the include path
package mbx_cmd_pkg;
	typedef enum logic [1:0] {
		fam_high_speed,
		fam_fsk,
		fam_facsimile,
		fam_medium_speed
	} modem_family_e;

	typedef enum logic [1:0] {
		ph_call_setup,
		ph_handshake,
		ph_data
	} call_phase_e;

	typedef logic [23:0] cmd_word_t;
endpackage : mbx_cmd_pkg

// >>> rtl/mbx_link_if.sv
// mbx_link_if.sv: three-byte mailbox between host controller and modem engine
// assumes: one clock shared by both ends; host owns the mailbox when out of reset
`timescale 1ns/1ps
interface mbx_link_if (
	input wire logic clock_i,
	input wire logic nrst_i
);
	mbx_cmd_pkg::cmd_word_t cmd_word;
	logic                   cmd_valid;
	logic                   cmd_wants_answer;
	logic [23:0]            resp_word;
	logic                   resp_valid;
	logic                   engine_ready;

	modport engine (
		input  cmd_word,
		input  cmd_valid,
		output resp_word,
		output resp_valid,
		output engine_ready
	);
	modport host (
		output cmd_word,
		output cmd_valid,
		output cmd_wants_answer,
		input  resp_word,
		input  resp_valid,
		input  engine_ready
	);
endinterface : mbx_link_if

// >>> rtl/mbx_cmd_classify.sv
// mbx_cmd_classify.sv: flags which commands return an answer in bytes 1 and 2
// assumes: pure combinational helper used by the host end
`timescale 1ns/1ps
`include "mbx_cmd_defs.svh"
module mbx_cmd_classify (
	// command
	input  wire logic [23:0] cmd_i,
	// classification
	output logic             wants_answer_o
);
	wire [7:0] op = cmd_i[`CMD_B0_MSB:`CMD_B0_LSB];
	assign wants_answer_o = (cmd_i == `OPF_FE_READ_A) || (cmd_i == `OPF_FE_READ_B)
		|| (op == `OPS_LOAD_ADDR_RD) || (op == `OPS_LOAD_ADDR_PAIR);
endmodule : mbx_cmd_classify

// >>> rtl/mbx_host_end.sv
// mbx_host_end.sv: host controller end; writes one command per mailbox exchange
// assumes: user side supplies commands; engine answers one cycle after a plain command, two after an answer-expecting one
`timescale 1ns/1ps
`include "mbx_cmd_defs.svh"
module mbx_host_end (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	// mailbox
	mbx_link_if.host          link,
	// user side
	input  wire logic         user_valid_i,
	input  wire logic [23:0]  user_cmd_i,
	input  wire logic         serial_active_i,
	output logic              user_ready_o,
	output logic [23:0]       status_o,
	output logic              status_valid_o
);
	logic        wants_answer;
	logic        answer_pending_reg;
	logic        cmd_valid_reg;
	logic [23:0] cmd_reg;
	logic [23:0] status_reg;
	logic        status_valid_reg;

	mbx_cmd_classify u_classify (
		.cmd_i          (user_cmd_i),
		.wants_answer_o (wants_answer)
	);

	wire [7:0] user_op  = user_cmd_i[`CMD_B0_MSB:`CMD_B0_LSB];
	// no send_data while serial mode active; scrambler commands are not filtered
	wire       forbidden = serial_active_i && (user_op == `OPS_SEND_DATA);
	// hold a second answer-expecting command until the first answer is back
	wire       blocked   = answer_pending_reg && wants_answer;
	wire       send_user = user_valid_i && !blocked && !forbidden;
	// with nothing to request, the idle command still goes out each exchange
	wire [23:0] next_cmd = send_user ? user_cmd_i : `OPF_IDLE;
	wire        take     = link.engine_ready && !cmd_valid_reg;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_valid_reg      <= 1'b0;
			cmd_reg            <= `OPF_IDLE;
			answer_pending_reg <= 1'b0;
			status_reg         <= `OPF_IDLE;
			status_valid_reg   <= 1'b0;
		end else begin
			cmd_valid_reg    <= take;
			status_valid_reg <= link.resp_valid;
			if (take) begin
				cmd_reg <= next_cmd;
			end
			if (link.resp_valid) begin
				status_reg <= link.resp_word;
			end
			// a new answer-expecting command sets pending; set wins over clear
			if (take && send_user && wants_answer) begin
				answer_pending_reg <= 1'b1;
			end else if (link.resp_valid) begin
				answer_pending_reg <= 1'b0;
			end
		end
	end

	assign link.cmd_word         = cmd_reg;
	assign link.cmd_valid        = cmd_valid_reg;
	assign link.cmd_wants_answer = answer_pending_reg;
	assign user_ready_o          = take && !blocked && !forbidden;
	assign status_o              = status_reg;
	assign status_valid_o        = status_valid_reg;
endmodule : mbx_host_end

// >>> dv/mbx_link_checker.sv
// mbx_link_checker.sv: timing and framing checks on the three-byte mailbox link
// assumes: placed beside mbx_link_if, one clock domain, reset active low
`timescale 1ns/1ps
module mbx_link_checker (
	// link signals
	input wire logic                   clock_i,
	input wire logic                   nrst_i,
	input wire mbx_cmd_pkg::cmd_word_t cmd_word,
	input wire logic                   cmd_valid,
	input wire logic                   cmd_wants_answer,
	input wire logic [23:0]            resp_word,
	input wire logic                   resp_valid,
	input wire logic                   engine_ready
);
	// answers come only for the two address reads and the two exact front-end reads
	wire is_ans = cmd_word == 24'h080000 || cmd_word == 24'h090000 || cmd_word[23:17] == 7'h08;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_plain_resp: assert property (cmd_valid && !is_ans |=> resp_valid)
		else $error("plain command without response one cycle later");
	a_answer_resp: assert property (cmd_valid && is_ans |=> !resp_valid ##1 resp_valid)
		else $error("answer not returned two cycles after command");
	a_cmd_spacing: assert property (cmd_valid |=> !cmd_valid)
		else $error("commands closer than two cycles");
	a_one_pending: assert property (cmd_valid && is_ans |=> !(cmd_valid && is_ans) [*2])
		else $error("second answer command while one pending");
	a_resp_cause: assert property (resp_valid |-> $past(cmd_valid) || $past(cmd_valid, 2))
		else $error("response without a command");
	a_resp_hold: assert property (!resp_valid |-> $stable(resp_word))
		else $error("response word changed without a response");
	a_ready_first: assert property ($rose(cmd_valid) |-> $past(engine_ready))
		else $error("command sent while engine not ready");
	a_status_fixed: assert property (resp_valid |-> resp_word[23:20] == 4'h0 && !resp_word[16])
		else $error("status byte zero bits set");
	a_hs_flag: assert property (resp_valid |-> resp_word[17] == (resp_word[19:18] == 2'b01))
		else $error("handshake flag disagrees with phase");
	a_pend_flag: assert property (cmd_valid && is_ans |-> cmd_wants_answer)
		else $error("no pending flag");
	a_idle_fill: assert property (engine_ready && !cmd_valid |=> cmd_valid)
		else $error("exchange skipped");
endmodule : mbx_link_checker

// >>> dv/test_modem_mailbox_command_decoder.sv
// test_modem_mailbox_command_decoder.sv: host end and engine end joined by the mailbox
// assumes: combinational memory model answers at the engine's address register
`timescale 1ns/1ps
module test_modem_mailbox_command_decoder;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        user_valid = 1'b0;
	logic [23:0] user_cmd = 24'h000000;
	logic        serial_active = 1'b0;
	logic [15:0] tx_sample = 16'h1000;
	logic [15:0] we_a, we_d, fe_d, m0, m1;
	logic [7:0]  sd, n_rt = 0, n_st = 0, n_sy = 0;
	int          n_fail = 0, checked = 0, cyc = 0;
	logic        user_ready, status_valid, mem_we, fe_setup, fe_wa, fe_wb, retrain, ec_fz, eq_fz;
	logic        tx_scr, rx_scr, fax_stop, fax_sync, ser_mode, send_data, ta_on, tb_on, fe_k;
	logic [23:0] status;
	logic [15:0] mem_addr, mem_wdata, fe_data, tx_out, ser_cfg, tone_a, tone_b, tone_sel;
	logic [7:0]  opts, send_byte, boost;
	mbx_cmd_pkg::call_phase_e   phase;
	mbx_cmd_pkg::modem_family_e family;
	logic [7:0]  fz [4] = '{8'h16, 8'h1b, 8'h17, 8'h1c};
	logic [1:0]  fzx [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
	logic [7:0]  cf [4] = '{8'h20, 8'h1d, 8'h1f, 8'h1e};
	mbx_cmd_pkg::modem_family_e fam [4] = '{mbx_cmd_pkg::fam_high_speed,
		mbx_cmd_pkg::fam_fsk, mbx_cmd_pkg::fam_facsimile, mbx_cmd_pkg::fam_medium_speed};

	always #10 clock_i = ~clock_i;

	// memory contents depend on both address bytes so a swapped address shows up
	function automatic logic [15:0] rd(input logic [15:0] a);
		return {a[7:0] ^ 8'h5a, a[15:8]};
	endfunction : rd

	mbx_link_if link (.clock_i(clock_i), .nrst_i(nrst_i));
	mbx_host_end mbx_host_end_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link),
		.user_valid_i(user_valid), .user_cmd_i(user_cmd), .serial_active_i(serial_active),
		.user_ready_o(user_ready), .status_o(status), .status_valid_o(status_valid));
	mbx_engine_end mbx_engine_end_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(link),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
		.mem_rdata_i(rd(mem_addr)), .mem_rdata_next_i(rd(mem_addr + 16'h0001)),
		.fe_data_o(fe_data), .fe_setup_o(fe_setup), .fe_write_a_o(fe_wa), .fe_write_b_o(fe_wb),
		.fe_status_a_i(12'h9a5), .fe_status_b_i(12'h3c6), .tx_sample_i(tx_sample),
		.tx_sample_o(tx_out), .phase_o(phase), .family_o(family), .family_opts_o(opts),
		.retrain_o(retrain), .ec_frozen_o(ec_fz), .eq_frozen_o(eq_fz),
		.tx_scrambler_on_o(tx_scr), .rx_scrambler_on_o(rx_scr), .fax_tx_stop_o(fax_stop),
		.fax_rx_sync_o(fax_sync), .serial_mode_o(ser_mode), .serial_cfg_o(ser_cfg),
		.send_data_o(send_data), .send_byte_o(send_byte), .tone_a_step_o(tone_a),
		.tone_b_step_o(tone_b), .tone_select_o(tone_sel), .tone_a_on_o(ta_on),
		.tone_b_on_o(tb_on), .tone_b_boost_db_o(boost));
	mbx_link_checker mbx_link_checker_inst (.clock_i(clock_i), .nrst_i(nrst_i),
		.cmd_word(link.cmd_word), .cmd_valid(link.cmd_valid),
		.cmd_wants_answer(link.cmd_wants_answer), .resp_word(link.resp_word),
		.resp_valid(link.resp_valid), .engine_ready(link.engine_ready));

	// strobes last one cycle, so catch them at the edge that samples them
	always @(posedge clock_i) begin
		cyc++;
		if (mem_we) begin
			we_a = mem_addr;
			we_d = mem_wdata;
		end
		if (fe_setup || fe_wa || fe_wb) {fe_k, fe_d} = {fe_wb, fe_data};
		if (send_data) sd = send_byte;
		if (retrain) n_rt++;
		if (fax_stop) n_st++;
		if (fax_sync) n_sy++;
		if (cyc == 6000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// one mailbox exchange: hand over a command, then wait for its status
	task automatic xch(input logic [23:0] c);
		int n;
		@(negedge clock_i);
		user_cmd = c;
		user_valid = 1'b1;
		for (n = 0; n < 50 && user_ready !== 1'b1; n++) @(negedge clock_i);
		@(negedge clock_i);
		user_valid = 1'b0;
		for (n = 0; n < 50 && status_valid !== 1'b1; n++) @(negedge clock_i);
	endtask : xch

	initial begin
		repeat (8) @(posedge clock_i);
		@(negedge clock_i);
		nrst_i = 1'b1;
		repeat (3) @(negedge clock_i);
		cmp("unity gain", 24'h001000, {8'h00, tx_out});
		xch(24'h020020);
		cmp("half gain", 24'h000800, {8'h00, tx_out});
		tx_sample = 16'hf000;
		repeat (2) @(negedge clock_i);
		cmp("negative sample", 24'h00f800, {8'h00, tx_out});
		xch(24'h103412);
		cmp("address", 24'h001234, {8'h00, mem_addr});
		cmp("read word", {8'h00, rd(16'h1234)}, {8'h00, status[15:0]});
		m0 = rd(16'h00ff);
		m1 = rd(16'h0100);
		xch(24'h11ff00);
		cmp("pair read", {8'h00, m0[15:8], m1[15:8]}, {8'h00, status[15:0]});
		cmp("pair address", 24'h0000ff, {8'h00, mem_addr});
		xch(24'h12cdab);
		cmp("store", 24'h00abcd, {8'h00, we_d});
		cmp("store kept address", 24'h00ffff, {we_a, mem_addr[7:0]});
		xch(24'h137788);
		cmp("store inc", 24'hff8877, {we_a[7:0], we_d});
		cmp("inc address", 24'h000100, {8'h00, mem_addr});
		for (int i = 0; i < 4; i++) begin
			xch({fz[i], 16'h0000});
			cmp("freeze", {22'h0, fzx[i]}, {22'h0, ec_fz, eq_fz});
			xch({cf[i], 16'h0500});
			cmp("family", {22'h0, fam[i]}, {22'h0, family});
			if (i == 0) cmp("options", 24'h000005, {16'h0, opts});
		end
		xch(24'h0eff7f);
		xch(24'h0f3412);
		cmp("tone steps", {8'h00, 16'h7fff}, {8'h00, tone_a});
		cmp("tone b step", 24'h001234, {8'h00, tone_b});
		xch(24'h0c1000);
		cmp("tone select", 24'h000010, {8'h00, tone_sel});
		cmp("tones still off", 24'h000000, {22'h0, ta_on, tb_on});
		xch(24'h0d0300);
		cmp("both tones", 24'h000302, {14'h0, ta_on, tb_on, boost});
		xch(24'h0d0200);
		cmp("tone b only", 24'h000001, {22'h0, ta_on, tb_on});
		xch(24'h180100);
		cmp("scrambler on", 24'h000001, {23'h0, tx_scr});
		xch(24'h180000);
		cmp("scrambler off", 24'h000000, {23'h0, tx_scr});
		xch(24'h150100);
		serial_active = 1'b1;
		cmp("serial on", 24'h010001, {7'h0, ser_mode, ser_cfg});
		xch(24'h150000);
		serial_active = 1'b0;
		cmp("serial off", 24'h000000, {7'h0, ser_mode, ser_cfg});
		xch(24'h015a00);
		cmp("send byte", 24'h00005a, {16'h0, sd});
		xch(24'h190000);
		xch(24'h1a0000);
		xch(24'h050000);
		cmp("fax and retrain", 24'h010101, {n_st, n_sy, n_rt});
		xch(24'h072143);
		cmp("fe setup", 24'h004321, {8'h00, fe_d});
		xch(24'h0a6587);
		cmp("fe write", 24'h008765, {7'h0, fe_k, fe_d});
		xch(24'h0b0fed);
		cmp("fe write b", 24'h01ed0f, {7'h0, fe_k, fe_d});
		xch(24'h080000);
		cmp("fe read a", 24'h0009a5, {8'h00, status[15:0]});
		xch(24'h090000);
		cmp("fe read b", 24'h0003c6, {8'h00, status[15:0]});
		xch(24'h080001);
		cmp("near read", 24'h000000, {8'h00, status[15:0]});
		xch(24'h040000);
		xch(24'h000000);
		cmp("training", {22'h0, mbx_cmd_pkg::ph_handshake}, {22'h0, phase});
		repeat (40) xch(24'h000000);
		cmp("data phase", {22'h0, mbx_cmd_pkg::ph_data}, {22'h0, phase});
		cmp("scramblers", 24'h000003, {22'h0, tx_scr, rx_scr});
		xch(24'h0600c0);
		cmp("init phase", {22'h0, mbx_cmd_pkg::ph_call_setup}, {22'h0, phase});
		cmp("init gain", 24'h00f000, {8'h00, tx_out});
		cmp("init tones", 24'h000000, {22'h0, ta_on, tb_on});
		summarize();
	end
endmodule : test_modem_mailbox_command_decoder
